// [rtl/smw_top.sv]
// Manageability watchdog: two-stage lock watchdog, fetch monitor, ECC and case-open events, function disable
//
// What this block does
// - First lock watchdog expiry raises a system-management interrupt pulse.
// - Second expiry without reload issues a full system reset pulse.
// - After reset, no first instruction fetch within the timeout reboots the system.
// - ECC message from host controller raises the interrupt its selector names.
// - Software can disable LAN, USB, LPC, SATA, PCI Express and SMBus individually.
// - A disabled function no longer claims I/O, memory or configuration accesses.
// - A disabled function passes no interrupts and no power management events.
// - Case-open input raises system-management or management interrupt, chosen by software.
//
// Chosen here: the AHB-Lite register port and the register addresses.
`include "smw_params.svh"

module smw_top #(
  parameter logic [23:0] FETCH_TIMEOUT_CYC = 24'(`SMW_FETCH_TIMEOUT_CYC)
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic i_fetch_seen,
  input wire logic i_ecc_msg_valid,
  input wire smw_pkg::smw_ecc_sel_type i_ecc_msg_sel,
  input wire logic i_case_open_n,
  input wire logic [`SMW_FN_W-1:0] i_fn_hit,
  input wire logic [`SMW_FN_W-1:0] i_fn_irq,
  input wire logic [`SMW_FN_W-1:0] i_fn_pme,
  output logic [`SMW_FN_W-1:0] o_fn_claim,
  output logic [`SMW_FN_W-1:0] o_fn_irq,
  output logic [`SMW_FN_W-1:0] o_fn_pme,
  output logic o_system_mgmt_irq,
  output logic o_nonmaskable_irq,
  output logic o_system_error_signal,
  output logic o_mgmt_irq,
  output logic o_sys_reset,
  output logic o_irq
);
  import smw_pkg::*;

  smw_state_type r_reg;
  smw_state_type r_next;

  logic addr_phase;
  logic kick;
  logic [`SMW_FN_W-1:0] fn_claim_v;
  logic [`SMW_FN_W-1:0] fn_irq_v;
  logic [`SMW_FN_W-1:0] fn_pme_v;

  // Only the transfer type is decoded; word size is assumed from the master
  assign addr_phase = i_hsel & i_htrans[1] & i_hready;
  assign kick = r_reg.wr_pend & (r_reg.wr_off == `SMW_OFF_RELOAD);

  // One gate set per integrated function, fed from the registered disable mask
  for (genvar g = 0; g < `SMW_FN_W; g++) begin : g_fn_gate
    assign fn_claim_v[g] = i_fn_hit[g] & ~r_reg.fn_dis[g];
    assign fn_irq_v[g] = i_fn_irq[g] & ~r_reg.fn_dis[g];
    assign fn_pme_v[g] = i_fn_pme[g] & ~r_reg.fn_dis[g];
  end

  always_comb begin
    logic [`SMW_ST_W-1:0] set_v;
    logic rd_clr;
    logic rst_trig;
    set_v = '0;
    rd_clr = 1'b0;
    rst_trig = 1'b0;
    r_next = r_reg;
    r_next.hready = 1'b1;
    r_next.hresp = 1'b0;
    r_next.rdata = 32'h0;
    r_next.wr_pend = 1'b0;
    r_next.smi = 1'b0;
    r_next.nmi = 1'b0;
    r_next.system_error_signal = 1'b0;
    r_next.mgmt = 1'b0;

    // Pin synchronisers
    r_next.case_s1 = ~i_case_open_n;
    r_next.case_s2 = r_reg.case_s1;
    r_next.case_q = r_reg.case_s2;
    r_next.fetch_s1 = i_fetch_seen;
    r_next.fetch_s2 = r_reg.fetch_s1;

    // Write data phase; unmapped offsets are dropped silently
    if (r_reg.wr_pend) begin
      case (r_reg.wr_off)
        `SMW_OFF_CTRL: r_next.ctrl = i_hwdata[`SMW_CTRL_W-1:0];
        `SMW_OFF_LOAD: r_next.load = i_hwdata[`SMW_LOAD_W-1:0];
        `SMW_OFF_FN_DIS: r_next.fn_dis = i_hwdata[`SMW_FN_W-1:0];
        `SMW_OFF_MASK: r_next.mask = i_hwdata[`SMW_ST_W-1:0];
        default: begin
        end
      endcase
    end

    // Address phase; read data is latched so it stands through the data phase
    if (addr_phase) begin
      if (i_hwrite) begin
        r_next.wr_pend = 1'b1;
        r_next.wr_off = i_haddr[7:0];
      end else begin
        case (i_haddr[7:0])
          `SMW_OFF_CTRL: r_next.rdata = {{(32-`SMW_CTRL_W){1'b0}}, r_reg.ctrl};
          `SMW_OFF_LOAD: r_next.rdata = {{(32-`SMW_LOAD_W){1'b0}}, r_reg.load};
          `SMW_OFF_FN_DIS: r_next.rdata = {{(32-`SMW_FN_W){1'b0}}, r_reg.fn_dis};
          `SMW_OFF_STATUS: begin
            r_next.rdata = {{(32-`SMW_ST_W){1'b0}}, r_reg.status};
            rd_clr = 1'b1;
          end
          `SMW_OFF_MASK: r_next.rdata = {{(32-`SMW_ST_W){1'b0}}, r_reg.mask};
          `SMW_OFF_WD_COUNT: r_next.rdata = {6'h0, r_reg.wd_state, r_reg.wd_cnt};
          default: r_next.rdata = 32'h0;
        endcase
      end
    end

    // Lock watchdog; clearing the enable parks it and drops any second stage
    case (r_reg.wd_state)
      SMW_WD_IDLE: begin
        if (r_reg.ctrl[`SMW_CTRL_WD_EN]) begin
          r_next.wd_state = SMW_WD_STAGE1;
          r_next.wd_cnt = r_reg.load;
        end
      end
      SMW_WD_STAGE1: begin
        if (!r_reg.ctrl[`SMW_CTRL_WD_EN]) begin
          r_next.wd_state = SMW_WD_IDLE;
        end else if (kick) begin
          r_next.wd_cnt = r_reg.load;
        end else if (r_reg.wd_cnt == '0) begin
          r_next.smi = 1'b1;
          set_v[`SMW_ST_WD_FIRST] = 1'b1;
          r_next.wd_state = SMW_WD_STAGE2;
          r_next.wd_cnt = r_reg.load;
        end else begin
          r_next.wd_cnt = r_reg.wd_cnt - 1'b1;
        end
      end
      SMW_WD_STAGE2: begin
        if (!r_reg.ctrl[`SMW_CTRL_WD_EN]) begin
          r_next.wd_state = SMW_WD_IDLE;
        end else if (kick) begin
          r_next.wd_state = SMW_WD_STAGE1;
          r_next.wd_cnt = r_reg.load;
        end else if (r_reg.wd_cnt == '0) begin
          rst_trig = 1'b1;
          set_v[`SMW_ST_WD_SECOND] = 1'b1;
          r_next.wd_state = SMW_WD_STAGE1;
          r_next.wd_cnt = r_reg.load;
        end else begin
          r_next.wd_cnt = r_reg.wd_cnt - 1'b1;
        end
      end
      default: r_next.wd_state = SMW_WD_IDLE;
    endcase

    // first fetch monitor, re-armed after each reboot it triggers itself, not after a watchdog reset
    case (r_reg.fetch_state)
      SMW_FT_WAIT: begin
        if (r_reg.fetch_s2) begin
          r_next.fetch_state = SMW_FT_SEEN;
        end else if (r_reg.fetch_cnt == FETCH_TIMEOUT_CYC - 24'h1) begin
          rst_trig = 1'b1;
          set_v[`SMW_ST_FETCH_TO] = 1'b1;
          r_next.fetch_cnt = 24'h0;
        end else begin
          r_next.fetch_cnt = r_reg.fetch_cnt + 24'h1;
        end
      end
      SMW_FT_SEEN: r_next.fetch_state = SMW_FT_SEEN;
      default: r_next.fetch_state = SMW_FT_WAIT;
    endcase

    if (i_ecc_msg_valid) begin
      set_v[`SMW_ST_ECC] = 1'b1;
      case (i_ecc_msg_sel)
        SMW_ECC_SMI: r_next.smi = 1'b1;
        SMW_ECC_NMI: r_next.nmi = 1'b1;
        SMW_ECC_SYSTEM_ERROR_SIGNAL: r_next.system_error_signal = 1'b1;
        SMW_ECC_MGMT: r_next.mgmt = 1'b1;
        default: r_next.smi = 1'b1;
      endcase
    end

    if (r_reg.case_s2 & ~r_reg.case_q) begin
      set_v[`SMW_ST_CASE_OPEN] = 1'b1;
      if (r_reg.ctrl[`SMW_CTRL_CASE_MGMT]) begin
        r_next.mgmt = 1'b1;
      end else begin
        r_next.smi = 1'b1;
      end
    end

    // Reset pulse stretcher; a new trigger restarts the full width
    if (rst_trig) begin
      r_next.rst_cnt = `SMW_RST_PULSE_CYC;
    end else if (r_reg.rst_cnt != 8'h0) begin
      r_next.rst_cnt = r_reg.rst_cnt - 8'h1;
    end
    r_next.sys_rst = (r_next.rst_cnt != 8'h0);

    // Set wins over the read clear, so no event is lost
    r_next.status = (r_reg.status & ~{`SMW_ST_W{rd_clr}}) | set_v;
    r_next.irq = |(r_next.status & r_next.mask);

    // Gated events registered so every output leaves a flip-flop
    r_next.fn_claim = fn_claim_v;
    r_next.fn_irq = fn_irq_v;
    r_next.fn_pme = fn_pme_v;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r_reg <= '0;
      r_reg.hready <= 1'b1;
      r_reg.load <= `SMW_LOAD_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_hreadyout = r_reg.hready;
  assign o_hresp = r_reg.hresp;
  assign o_hrdata = r_reg.rdata;
  assign o_fn_claim = r_reg.fn_claim;
  assign o_fn_irq = r_reg.fn_irq;
  assign o_fn_pme = r_reg.fn_pme;
  assign o_system_mgmt_irq = r_reg.smi;
  assign o_nonmaskable_irq = r_reg.nmi;
  assign o_system_error_signal = r_reg.system_error_signal;
  assign o_mgmt_irq = r_reg.mgmt;
  assign o_sys_reset = r_reg.sys_rst;
  assign o_irq = r_reg.irq;

endmodule : smw_top

// [rtl/smw_params.svh]
// Register map, field positions, reset values and timing constants of the manageability watchdog
`ifndef SMW_PARAMS_SVH
`define SMW_PARAMS_SVH

`define SMW_CLK_MHZ 10
`define SMW_FETCH_TIMEOUT_US 1000
`define SMW_FETCH_TIMEOUT_CYC (`SMW_FETCH_TIMEOUT_US * `SMW_CLK_MHZ)
`define SMW_RST_PULSE_CYC 8'h10

`define SMW_OFF_CTRL 8'h00
`define SMW_OFF_LOAD 8'h04
`define SMW_OFF_RELOAD 8'h08
`define SMW_OFF_FN_DIS 8'h0c
`define SMW_OFF_STATUS 8'h10
`define SMW_OFF_MASK 8'h14
`define SMW_OFF_WD_COUNT 8'h18

`define SMW_CTRL_WD_EN 0
`define SMW_CTRL_CASE_MGMT 1
`define SMW_CTRL_W 2

`define SMW_LOAD_W 24
`define SMW_LOAD_RST 24'hffffff

`define SMW_ST_WD_FIRST 0
`define SMW_ST_WD_SECOND 1
`define SMW_ST_FETCH_TO 2
`define SMW_ST_CASE_OPEN 3
`define SMW_ST_ECC 4
`define SMW_ST_W 5

`define SMW_FN_LAN 0
`define SMW_FN_USB 1
`define SMW_FN_LPC 2
`define SMW_FN_SATA 3
`define SMW_FN_PCIE 4
`define SMW_FN_SMBUS 5
`define SMW_FN_W 6

`endif

// [rtl/smw_pkg.sv]
// Types of the manageability watchdog: states, ECC message selector and the state record
`include "smw_params.svh"

package smw_pkg;

  typedef enum logic [1:0] {
    SMW_WD_IDLE = 2'b00,
    SMW_WD_STAGE1 = 2'b01,
    SMW_WD_STAGE2 = 2'b11
  } smw_wd_state_type;

  typedef enum logic {
    SMW_FT_WAIT = 1'b0,
    SMW_FT_SEEN = 1'b1
  } smw_fetch_state_type;

  typedef enum logic [1:0] {
    SMW_ECC_SMI = 2'b00,
    SMW_ECC_NMI = 2'b01,
    SMW_ECC_SYSTEM_ERROR_SIGNAL = 2'b10,
    SMW_ECC_MGMT = 2'b11
  } smw_ecc_sel_type;

  typedef struct packed {
    logic hready;
    logic hresp;
    logic [31:0] rdata;
    logic wr_pend;
    logic [7:0] wr_off;
    logic [`SMW_CTRL_W-1:0] ctrl;
    logic [`SMW_LOAD_W-1:0] load;
    logic [`SMW_FN_W-1:0] fn_dis;
    logic [`SMW_ST_W-1:0] status;
    logic [`SMW_ST_W-1:0] mask;
    logic irq;
    smw_wd_state_type wd_state;
    logic [`SMW_LOAD_W-1:0] wd_cnt;
    smw_fetch_state_type fetch_state;
    logic [23:0] fetch_cnt;
    logic [7:0] rst_cnt;
    logic sys_rst;
    logic smi;
    logic nmi;
    logic system_error_signal;
    logic mgmt;
    logic case_s1;
    logic case_s2;
    logic case_q;
    logic fetch_s1;
    logic fetch_s2;
    logic [`SMW_FN_W-1:0] fn_claim;
    logic [`SMW_FN_W-1:0] fn_irq;
    logic [`SMW_FN_W-1:0] fn_pme;
  } smw_state_type;

endpackage : smw_pkg

// [test/smw_host_model.sv]
// Host processor and host controller seen from the watchdog
module smw_host_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ecc_req,
  input wire smw_pkg::smw_ecc_sel_type i_ecc_req_sel,
  input wire logic i_fetch_go,
  input wire logic i_sys_reset,
  output logic o_ecc_msg_valid,
  output smw_pkg::smw_ecc_sel_type o_ecc_msg_sel,
  output logic o_fetch_seen
);
  timeunit 1ns;
  timeprecision 1ns;
  import smw_pkg::*;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ecc_msg_valid <= 1'b0;
      o_ecc_msg_sel <= SMW_ECC_SMI;
      o_fetch_seen <= 1'b0;
    end else begin
      o_ecc_msg_valid <= i_ecc_req;
      // Idle selector toggles so a stale value is never trusted
      o_ecc_msg_sel <= i_ecc_req ? i_ecc_req_sel : smw_ecc_sel_type'(~o_ecc_msg_sel);
      // Reset restarts the processor before its fetch
      o_fetch_seen <= i_fetch_go && !i_sys_reset;
    end
  end
endmodule : smw_host_model

// [test/smw_assertions.sv]
// Port checker of the manageability watchdog
`include "smw_params.svh"
module smw_checker (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ecc_msg_valid,
  input wire smw_pkg::smw_ecc_sel_type i_ecc_msg_sel,
  input wire logic [`SMW_FN_W-1:0] i_fn_hit,
  input wire logic [`SMW_FN_W-1:0] i_fn_irq,
  input wire logic [`SMW_FN_W-1:0] i_fn_pme,
  input wire logic [`SMW_FN_W-1:0] o_fn_claim,
  input wire logic [`SMW_FN_W-1:0] o_fn_irq,
  input wire logic [`SMW_FN_W-1:0] o_fn_pme,
  input wire logic o_system_mgmt_irq,
  input wire logic o_nonmaskable_irq,
  input wire logic o_system_error_signal,
  input wire logic o_mgmt_irq,
  input wire logic o_sys_reset
);
  import smw_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_rst_run8;
    o_sys_reset [*8];
  endsequence
  property p_ecc(smw_ecc_sel_type s, logic o);
    i_ecc_msg_valid && i_ecc_msg_sel == s |=> o;
  endproperty
  a_ecc_smi_route: assert property (p_ecc(SMW_ECC_SMI, o_system_mgmt_irq))
    else $error("ECC message gave no system interrupt");
  a_ecc_nmi_route: assert property (p_ecc(SMW_ECC_NMI, o_nonmaskable_irq))
    else $error("ECC message gave no nonmaskable interrupt");
  a_ecc_system_error_signal_route: assert property (p_ecc(SMW_ECC_SYSTEM_ERROR_SIGNAL, o_system_error_signal))
    else $error("ECC message gave no system error");
  a_ecc_mgmt_route: assert property (p_ecc(SMW_ECC_MGMT, o_mgmt_irq))
    else $error("ECC message gave no management interrupt");
  a_nmi_cause_only: assert property (o_nonmaskable_irq |-> $past(i_ecc_msg_valid) && $past(i_ecc_msg_sel) == SMW_ECC_NMI)
    else $error("Nonmaskable interrupt without its message");
  a_fn_claim_gate: assert property ((o_fn_claim & ~$past(i_fn_hit)) == '0)
    else $error("Claim without a decode hit");
  a_fn_event_gate: assert property (((o_fn_irq & ~$past(i_fn_irq)) | (o_fn_pme & ~$past(i_fn_pme))) == '0)
    else $error("Function event without its source");
  a_reset_pulse_width: assert property ($rose(o_sys_reset) |-> s_rst_run8 ##1 s_rst_run8 ##1 !o_sys_reset)
    else $error("System reset pulse not sixteen cycles");
endmodule : smw_checker
bind smw_top smw_checker i_smw_checker (.*);

// [test/test_system_manageability_watchdog.sv]
// Self-checking bench of the manageability watchdog
`include "smw_params.svh"
module test_system_manageability_watchdog;
  timeunit 1ns;
  timeprecision 1ns;
  import smw_pkg::*;
  logic i_clk = 1'b0, i_rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, ecc_req = 1'b0, fetch_go = 1'b0;
  logic case_n = 1'b1, rst_q = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [5:0] fn_in = 6'h3c, dis, claim, firq, fpme;
  logic hready, hresp, ecc_v, fetch, smi, nmi, system_error_signal, mgmt, sys_rst, irq;
  smw_ecc_sel_type req_sel = SMW_ECC_SMI, ecc_sel;
  // Selector beside expected smi, nmi, system_error_signal, mgmt
  logic [5:0] rows [4] = '{6'h08, 6'h14, 6'h22, 6'h31};
  int error_cnt = 0, n_tests = 0, n_rst = 0, n_smi = 0, n_mgmt = 0, k, s0, m0;
  always #50 i_clk = ~i_clk;
  // Counted off the edge so a one-cycle pulse is seen exactly once
  always @(negedge i_clk) begin
    n_rst += int'(sys_rst && !rst_q);
    rst_q <= sys_rst;
    n_smi += int'(smi);
    n_mgmt += int'(mgmt);
  end
  smw_top #(.FETCH_TIMEOUT_CYC(24'h40)) i_smw_top (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
    .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata), .i_fetch_seen(fetch), .i_ecc_msg_valid(ecc_v),
    .i_ecc_msg_sel(ecc_sel), .i_case_open_n(case_n), .i_fn_hit(fn_in), .i_fn_irq(~fn_in), .i_fn_pme(fn_in),
    .o_fn_claim(claim), .o_fn_irq(firq), .o_fn_pme(fpme), .o_system_mgmt_irq(smi), .o_nonmaskable_irq(nmi),
    .o_system_error_signal(system_error_signal), .o_mgmt_irq(mgmt), .o_sys_reset(sys_rst), .o_irq(irq));
  smw_host_model i_smw_host_model (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ecc_req(ecc_req), .i_ecc_req_sel(req_sel),
    .i_fetch_go(fetch_go), .i_sys_reset(sys_rst), .o_ecc_msg_valid(ecc_v), .o_ecc_msg_sel(ecc_sel),
    .o_fetch_seen(fetch));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    logic rsp;
    @(posedge i_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    // Slave outputs are registered: sample them settled, before the edge that ends the phase
    do begin
      @(negedge i_clk);
      ok = hready;
      @(posedge i_clk);
    end while (ok !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(negedge i_clk);
      ok = hready;
      rsp = hresp;
      rd = hrdata;
      @(posedge i_clk);
    end while (ok !== 1'b1);
    check(rsp, 1'b0);
  endtask : bus
  task automatic ecc(input smw_ecc_sel_type s);
    @(posedge i_clk);
    ecc_req <= 1'b1;
    req_sel <= s;
    @(posedge i_clk);
    ecc_req <= 1'b0;
    @(posedge i_clk);
    #1;
  endtask : ecc
  task automatic wait_for(ref logic s, output int n);
    n = 0;
    while (s !== 1'b1) begin
      @(posedge i_clk);
      #1;
      n++;
    end
  endtask : wait_for
  task automatic print_verdict;
    if (error_cnt == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  initial begin
    // Whole run needs about 320 cycles
    #200000;
    error_cnt++;
    print_verdict;
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    wait_for(sys_rst, k);
    check(k >= 60 && k <= 72, 1);
    @(posedge i_clk);
    fetch_go <= 1'b1;
    bus(1'b0, `SMW_OFF_LOAD, 32'h0);
    check(rd, 32'h00ffffff);
    bus(1'b0, 8'h1c, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, `SMW_OFF_STATUS, 32'h0);
    check(rd, 32'h4);
    for (k = 0; k < 4; k++) begin
      ecc(smw_ecc_sel_type'(rows[k][5:4]));
      check({smi, nmi, system_error_signal, mgmt}, rows[k][3:0]);
    end
    bus(1'b1, `SMW_OFF_MASK, 32'h10);
    bus(1'b0, `SMW_OFF_STATUS, 32'h0);
    check(rd, 32'h10);
    @(posedge i_clk);
    #1;
    check(irq, 0);
    ecc(SMW_ECC_NMI);
    @(posedge i_clk);
    #1;
    check(irq, 1);
    bus(1'b1, `SMW_OFF_MASK, 32'h0);
    @(posedge i_clk);
    #1;
    check(irq, 0);
    bus(1'b0, `SMW_OFF_STATUS, 32'h0);
    for (k = 0; k < 2; k++) begin
      bus(1'b1, `SMW_OFF_CTRL, 32'(k * 2));
      s0 = n_smi;
      m0 = n_mgmt;
      case_n <= 1'b0;
      repeat (10) @(posedge i_clk);
      case_n <= 1'b1;
      repeat (4) @(posedge i_clk);
      #1;
      check(n_smi - s0, k == 0);
      check(n_mgmt - m0, k == 1);
    end
    bus(1'b0, `SMW_OFF_STATUS, 32'h0);
    check(rd, 32'h8);
    bus(1'b1, `SMW_OFF_LOAD, 32'd20);
    bus(1'b1, `SMW_OFF_CTRL, 32'h1);
    wait_for(smi, k);
    check(k >= 18 && k <= 26, 1);
    wait_for(sys_rst, k);
    check(k >= 19 && k <= 23, 1);
    s0 = n_smi;
    for (k = 0; k < 8; k++) begin
      repeat (10) @(posedge i_clk);
      bus(1'b1, `SMW_OFF_RELOAD, 32'h0);
    end
    check(n_smi - s0, 0);
    bus(1'b1, `SMW_OFF_CTRL, 32'h0);
    bus(1'b0, `SMW_OFF_STATUS, 32'h0);
    check(rd, 32'h3);
    check(n_rst, 2);
    for (k = 0; k < 2; k++) begin
      dis = k ? 6'h2a : 6'h15;
      bus(1'b1, `SMW_OFF_FN_DIS, {26'h0, dis});
      fn_in <= ~fn_in;
      repeat (2) @(posedge i_clk);
      #1;
      check({claim, firq, fpme}, {fn_in & ~dis, ~fn_in & ~dis, fn_in & ~dis});
    end
    print_verdict;
  end
endmodule : test_system_manageability_watchdog
